/* File: design/saq_pkg.sv */
// package of constants, tables and carriers for the sub-band adaptive quantizer
package saq_pkg;

  // data widths and fixed-point formats
  localparam int E_W = 16;          // difference signals, signed integer
  localparam int DELTA_W = 15;      // linear scale factors, unsigned integer
  localparam int LVL_FRAC = 13;     // table levels carry 13 fraction bits
  localparam int NAB_FRAC = 11;     // log scale factors carry 11 fraction bits
  localparam int NAB_W = 16;
  localparam int D_W = 19;          // signed quantized differences
  localparam int LO_INTERVALS = 30;
  localparam int LEAK_SHIFT = 7;    // leakage 127/128 as x - x/128

  // lower-band interval floors, index m-1 (0, 0.06817 ... 5.70214 in Q13)
  localparam logic [15:0] LO_FLOOR [0:LO_INTERVALS-1] = '{
    16'h0000, 16'h022e, 16'h0483, 16'h06d8, 16'h0959, 16'h0bda, 16'h0e8e, 16'h1142,
    16'h1432, 16'h1722, 16'h1a59, 16'h1d90, 16'h211d, 16'h24ab, 16'h28a3, 16'h2c9b,
    16'h311a, 16'h3598, 16'h3ac7, 16'h3ff6, 16'h4615, 16'h4c34, 16'h53ad, 16'h5b26,
    16'h64be, 16'h6e57, 16'h7bc5, 16'h8936, 16'h9fd7, 16'hb678};

  // lower-band output codes: positive code is base minus m for every m,
  // negative code has two forms (m 1..2 and m 3..30)
  localparam logic [5:0] LO_POS_BASE = 6'h3e;
  // 64 - m wraps to 0 - m in six bits, so the small negative base is zero
  localparam logic [5:0] LO_NEG_BASE_SMALL = 6'h00;
  localparam logic [5:0] LO_NEG_BASE = 6'h22;
  localparam logic [5:0] LO_SUBST_CODE = 6'h3f;   // replaces 0000xx

  // four-bit inverse magnitudes per group of four intervals, two (m 1..2) in group 0 (Q13)
  localparam logic [15:0] LO_INV4 [0:7] = '{
    16'h0000, 16'h0959, 16'h1432, 16'h211d, 16'h311a, 16'h4615, 16'h64be, 16'h9fd7};
  // log multipliers per group (Q11, -0.02930 ... 1.48535)
  localparam logic signed [15:0] LO_WMUL [0:7] = '{
    16'hffc4, 16'hffe2, 16'h003a, 16'h00ac, 16'h014e, 16'h021a, 16'h04ae, 16'h0be2};

  // higher band: split level 1.10156, inverse 0.39453 (Q13)
  localparam logic [15:0] HI_SPLIT = 16'h2340;
  localparam logic [15:0] HI_INV2 = 16'h0ca0;
  localparam logic signed [15:0] HI_WMUL_LOW = 16'hff2a;   // -0.10449 in Q11
  localparam logic signed [15:0] HI_WMUL_HIGH = 16'h031e;  // 0.38965 in Q11
  localparam logic [1:0] HI_NEG_LOW = 2'h1;
  localparam logic [1:0] HI_POS_LOW = 2'h3;
  localparam logic [1:0] HI_NEG_HIGH = 2'h0;
  localparam logic [1:0] HI_POS_HIGH = 2'h2;

  // log scale factor ceilings: 9 and 11 in Q11
  localparam logic [15:0] NAB_L_MAX = 16'h4800;
  localparam logic [15:0] NAB_H_MAX = 16'h5800;

  // split-band filter half set h0..h11 in Q15, mirrored for h12..h23
  localparam int QMF_TAPS = 24;
  localparam logic signed [15:0] QMF_HALF [0:11] = '{
    16'h000c, 16'hffd4, 16'hffd4, 16'h00d4, 16'h0030, 16'hfd90,
    16'h0080, 16'h05a8, 16'hfcb8, 16'hf36c, 16'h0edc, 16'h3c90};

  // one sub-band sample worth of inputs
  typedef struct packed {
    logic signed [E_W-1:0] e_l;
    logic signed [E_W-1:0] e_h;
    logic [DELTA_W-1:0] delta_l;
    logic [DELTA_W-1:0] delta_h;
  } saq_sample_t;

  // one sub-band sample worth of results
  typedef struct packed {
    logic [5:0] low_code;
    logic [1:0] high_code;
    logic [3:0] truncated_low_codeword;
    logic signed [D_W-1:0] truncated_quantized_difference;
    logic signed [D_W-1:0] high_quantized_difference;
  } saq_result_t;

  localparam saq_result_t RES_RESET = '{low_code: 6'h3f, high_code: 2'h3,
    truncated_low_codeword: 4'hf, truncated_quantized_difference: 19'h00000,
    high_quantized_difference: 19'h00000};

endpackage

/* File: design/saq_quantizer.sv */
// adaptive quantizer, truncated inverse quantizer and log scale factor update
// Contract
// - lower band to 6 bits, higher to 2
// - negative values classified by mirrored magnitude levels
// - scaled floor <= value < scaled ceiling selects interval
// - sign of difference picks positive or negative code
// - thirty lower intervals with listed levels and codes
// - never emit 0000xx; substitute 111111 when seen
// - higher band splits at 1.10156 times scale
// - drop two low bits for truncated codeword
// - truncated difference is inverse magnitude times scale, signed
// - four intervals share one four-bit inverse value, two (m 1..2) for the innermost
// - symmetric 24-tap split-band coefficient set
// - feedback path always uses four-bit truncated codeword
// - log scale factors leak 127/128, add multiplier, clamp
// - higher difference is 0.39453 times scale, signed
`timescale 1ns/1ps
`default_nettype none

module saq_quantizer (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic SAMPLE_I,
  input wire saq_pkg::saq_sample_t SAMP_I,
  input wire logic [4:0] COEF_IDX_I,
  output logic VALID_O,
  output saq_pkg::saq_result_t RES_O,
  output logic [15:0] NABLA_L_O,
  output logic [15:0] NABLA_H_O,
  output logic signed [15:0] COEF_O
);
  import saq_pkg::*;

  // group of four intervals recovered from a truncated codeword
  function automatic logic [2:0] group_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code == 4'h0) ? LO_SUBST_CODE[5:2] : code;
    if (c[3]) begin
      group_of = 3'(4'hf - c);
    end else begin
      group_of = 3'(4'h8 - c);
    end
  endfunction

  logic [E_W:0] mag_l;
  logic [E_W:0] mag_h;
  logic [31:0] mag_l_q;
  logic [31:0] mag_h_q;
  logic [LO_INTERVALS-1:0] above;
  logic [4:0] m_l;
  logic [5:0] code_l;
  logic [1:0] code_h;
  logic hi_upper;
  logic [3:0] trunc;
  logic [2:0] grp;
  logic [31:0] prod_lt;
  logic [31:0] prod_h;
  logic [D_W-1:0] mag_lt;
  logic [D_W-1:0] mag_dh;
  saq_result_t res;
  saq_result_t next_res;
  logic valid;
  logic next_valid;
  logic [15:0] nab_l;
  logic [15:0] nab_h;
  logic [15:0] next_nab_l;
  logic [15:0] next_nab_h;
  logic signed [15:0] coef;
  logic signed [15:0] next_coef;

  // magnitudes in Q13 so they meet the table levels directly
  always_comb begin
    mag_l = SAMP_I.e_l[E_W-1] ? (E_W+1)'(-SAMP_I.e_l) : (E_W+1)'(SAMP_I.e_l);
    mag_h = SAMP_I.e_h[E_W-1] ? (E_W+1)'(-SAMP_I.e_h) : (E_W+1)'(SAMP_I.e_h);
    mag_l_q = 32'(mag_l) << LVL_FRAC;
    mag_h_q = 32'(mag_h) << LVL_FRAC;
  end

  // one comparator per interval floor; floors rise, so the count is the index
  genvar k;
  generate
    for (k = 0; k < LO_INTERVALS; k++) begin : g_floor
      assign above[k] = mag_l_q >= 32'(LO_FLOOR[k]) * 32'(SAMP_I.delta_l);
    end
  endgenerate

  // interval index, codes and inverse quantization
  always_comb begin
    m_l = 5'h0;
    for (int i = 0; i < LO_INTERVALS; i++) begin
      m_l = m_l + 5'(above[i]);
    end
    // m_l is 1..30; floor zero always passes
    if (!SAMP_I.e_l[E_W-1]) begin
      code_l = LO_POS_BASE - 6'(m_l);
    end else if (m_l <= 5'h2) begin
      code_l = LO_NEG_BASE_SMALL - 6'(m_l);
    end else begin
      code_l = LO_NEG_BASE - 6'(m_l);
    end
    hi_upper = mag_h_q >= 32'(HI_SPLIT) * 32'(SAMP_I.delta_h);
    if (!SAMP_I.e_h[E_W-1]) begin
      code_h = hi_upper ? HI_POS_HIGH : HI_POS_LOW;
    end else begin
      code_h = hi_upper ? HI_NEG_HIGH : HI_NEG_LOW;
    end
    trunc = code_l[5:2];
    grp = group_of(trunc);
    prod_lt = 32'(LO_INV4[grp]) * 32'(SAMP_I.delta_l);
    prod_h = 32'(HI_INV2) * 32'(SAMP_I.delta_h);
    mag_lt = D_W'(prod_lt >> LVL_FRAC);
    mag_dh = D_W'(prod_h >> LVL_FRAC);
    next_res.low_code = code_l;
    next_res.high_code = code_h;
    next_res.truncated_low_codeword = trunc;
    // sign comes from the difference, not the code: intervals 1..2 share 1111
    next_res.truncated_quantized_difference = SAMP_I.e_l[E_W-1] ? -mag_lt : mag_lt;
    next_res.high_quantized_difference = SAMP_I.e_h[E_W-1] ? -mag_dh : mag_dh;
    next_valid = SAMPLE_I;
  end

  // results are captured only on a sample strobe and then held
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      res <= RES_RESET;
      valid <= 1'b0;
    end else if (CE_I) begin
      if (SAMPLE_I) begin
        res <= next_res;
      end
      valid <= next_valid;
    end
  end

  // log scale factors advance with the previous sample's codes; a wide signed
  // sum lets the clamp see both underflow and overflow
  always_comb begin
    logic signed [17:0] sum_l;
    logic signed [17:0] sum_h;
    logic signed [15:0] w_h;
    sum_l = 18'sh0;
    sum_h = 18'sh0;
    w_h = res.high_code[0] ? HI_WMUL_LOW : HI_WMUL_HIGH;
    sum_l = $signed({2'b00, nab_l}) - $signed({2'b00, nab_l >> LEAK_SHIFT})
            + 18'(LO_WMUL[group_of(res.truncated_low_codeword)]);
    sum_h = $signed({2'b00, nab_h}) - $signed({2'b00, nab_h >> LEAK_SHIFT})
            + 18'(w_h);
    next_nab_l = nab_l;
    next_nab_h = nab_h;
    if (SAMPLE_I) begin
      if (sum_l < 0) begin
        next_nab_l = 16'h0000;
      end else if (sum_l > $signed({2'b00, NAB_L_MAX})) begin
        next_nab_l = NAB_L_MAX;
      end else begin
        next_nab_l = sum_l[15:0];
      end
      if (sum_h < 0) begin
        next_nab_h = 16'h0000;
      end else if (sum_h > $signed({2'b00, NAB_H_MAX})) begin
        next_nab_h = NAB_H_MAX;
      end else begin
        next_nab_h = sum_h[15:0];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      nab_l <= 16'h0000;
      nab_h <= 16'h0000;
    end else if (CE_I) begin
      nab_l <= next_nab_l;
      nab_h <= next_nab_h;
    end
  end

  // coefficient lookup; the upper half mirrors the lower half
  always_comb begin
    if (COEF_IDX_I < 5'(QMF_TAPS / 2)) begin
      next_coef = QMF_HALF[COEF_IDX_I[3:0]];
    end else if (COEF_IDX_I < 5'(QMF_TAPS)) begin
      next_coef = QMF_HALF[4'(5'(QMF_TAPS - 1) - COEF_IDX_I)];
    end else begin
      next_coef = 16'sh0000;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      coef <= 16'sh0000;
    end else if (CE_I) begin
      coef <= next_coef;
    end
  end

  assign VALID_O = valid;
  assign RES_O = res;
  assign NABLA_L_O = nab_l;
  assign NABLA_H_O = nab_h;
  assign COEF_O = coef;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_VALID_NEXT: assert property (SAMPLE_I && CE_I |=> valid)
    else $error("result not flagged one cycle after sample");
  AST_NO_SUPPRESSED: assert property (res.low_code[5:2] != 4'h0)
    else $error("suppressed lower code emitted");
  AST_TRUNC_BITS: assert property (valid |->
      res.truncated_low_codeword == res.low_code[5:2])
    else $error("truncated codeword is not top four bits");
  AST_HI_SIGN: assert property (SAMPLE_I && CE_I |=>
      res.high_code[1] == !$past(SAMP_I.e_h[E_W-1]))
    else $error("higher code sign bit wrong");
  AST_HI_SPLIT: assert property (SAMPLE_I && CE_I && !hi_upper |=> res.high_code[0])
    else $error("higher code interval wrong below split");
  AST_HI_DIFF: assert property (SAMPLE_I && CE_I && !SAMP_I.e_h[E_W-1] |=>
      res.high_quantized_difference ==
      D_W'((32'(HI_INV2) * 32'($past(SAMP_I.delta_h))) >> LVL_FRAC))
    else $error("higher quantized difference wrong");
  AST_ZERO_GROUP: assert property (valid && res.truncated_low_codeword == 4'hf |->
      res.truncated_quantized_difference == 19'sh0)
    else $error("innermost group not zero");
  AST_LT_SIGN: assert property (SAMPLE_I && CE_I && SAMP_I.e_l[E_W-1] |=>
      res.truncated_quantized_difference <= 0)
    else $error("truncated difference sign wrong");
  AST_TOP_INTERVAL: assert property (SAMPLE_I && CE_I && above[LO_INTERVALS-1] |=>
      res.low_code[5:2] == 4'h8 || res.low_code[5:2] == 4'h1)
    else $error("top interval code wrong");
  AST_NAB_RANGE: assert property (nab_l <= NAB_L_MAX && nab_h <= NAB_H_MAX)
    else $error("log scale factor out of range");
  AST_NAB_HOLD: assert property (!SAMPLE_I |=> $stable(nab_l) && $stable(nab_h))
    else $error("log scale factor moved without sample");
  // a low enable must freeze every register, results and log factors alike
  AST_CE_FREEZE: assert property (!CE_I |=>
      $stable(res) && $stable(valid) && $stable(nab_l) && $stable(nab_h) && $stable(coef))
    else $error("state moved while enable low");
  // both ends of the set must read the same outermost coefficient
  AST_COEF_SYM: assert property (CE_I && (COEF_IDX_I == 5'h0 || COEF_IDX_I == 5'h17) |=>
      coef == QMF_HALF[0])
    else $error("coefficient lookup wrong");

endmodule

`default_nettype wire

/* File: bench/saq_far_end.sv */
// far-end model: supplies one sample per strobe and logs every result
`timescale 1ns/1ps
`default_nettype none
module saq_far_end (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire saq_pkg::saq_result_t res_i,
  input wire logic [15:0] nabla_l_i,
  input wire logic [15:0] nabla_h_i,
  output logic sample_o,
  output saq_pkg::saq_sample_t samp_o
);
  import saq_pkg::*;
  logic [$bits(saq_result_t)+31:0] seen [$];
  initial begin
    sample_o = 1'b0;
    samp_o = '0;
  end
  // keep leaves the strobe up so the next call follows back to back
  task automatic send(input saq_sample_t s, input bit keep);
    @(negedge clk_i);
    sample_o = 1'b1;
    samp_o = s;
    if (!keep) begin
      @(negedge clk_i);
      sample_o = 1'b0;
      samp_o = ~s; // stale data must never pass for a fresh sample
    end
  endtask
  // every result pulse is logged with its log scale factors; the falling
  // edge sees settled outputs, well away from the edge that launches them
  always @(negedge clk_i) begin
    if (valid_i) begin
      seen.push_back({res_i, nabla_l_i, nabla_h_i});
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the sub-band adaptive quantizer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import saq_pkg::*;
  logic CLK_I;
  logic RST_N_I;
  logic CE_I;
  logic SAMPLE_I;
  saq_sample_t SAMP_I;
  logic [4:0] COEF_IDX_I;
  logic VALID_O;
  saq_result_t RES_O;
  logic [15:0] NABLA_L_O;
  logic [15:0] NABLA_H_O;
  logic signed [15:0] COEF_O;
  int err_count;
  int compares;
  logic [$bits(saq_result_t)+31:0] want [$];
  int nl;
  int nh;
  int pm;
  bit pu;

  saq_quantizer dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .SAMPLE_I(SAMPLE_I),
    .SAMP_I(SAMP_I), .COEF_IDX_I(COEF_IDX_I), .VALID_O(VALID_O), .RES_O(RES_O),
    .NABLA_L_O(NABLA_L_O), .NABLA_H_O(NABLA_H_O), .COEF_O(COEF_O));
  saq_far_end far_u (.clk_i(CLK_I), .valid_i(VALID_O), .res_i(RES_O), .nabla_l_i(NABLA_L_O),
    .nabla_h_i(NABLA_H_O), .sample_o(SAMPLE_I), .samp_o(SAMP_I));

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] wv);
    compares++;
    if (seen !== wv) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, wv, seen);
    end
  endtask

  // expected result worked out from the decision levels, then the sample is sent
  task automatic put(input int el, input int eh, input int dl, input int dh, input bit keep);
    longint al;
    longint ah;
    longint ql;
    longint qh;
    int m;
    bit up;
    logic [5:0] lc;
    logic [1:0] hc;
    al = (el < 0) ? -el : el;
    ah = (eh < 0) ? -eh : eh;
    m = 1;
    for (int k = 1; k < 30; k++) if (longint'(LO_FLOOR[k]) * dl <= al * 8192) m = k + 1;
    lc = (el >= 0) ? 6'(62 - m) : (m <= 2) ? 6'(64 - m) : 6'(34 - m);
    up = ah * 8192 >= longint'(16'h2340) * dh;
    hc = up ? ((eh < 0) ? 2'h0 : 2'h2) : ((eh < 0) ? 2'h1 : 2'h3);
    ql = (longint'(LO_INV4[(m + 1) / 4]) * dl) >> 13;
    qh = (longint'(HI_INV2) * dh) >> 13;
    if (el < 0) ql = -ql;
    if (eh < 0) qh = -qh;
    // log factors use the codes of the sample before this one
    nl = nl - (nl >> 7) + int'(LO_WMUL[(pm + 1) / 4]);
    nh = nh - (nh >> 7) + int'(pu ? HI_WMUL_HIGH : HI_WMUL_LOW);
    nl = (nl < 0) ? 0 : (nl > 9 * 2048) ? 9 * 2048 : nl;
    nh = (nh < 0) ? 0 : (nh > 11 * 2048) ? 11 * 2048 : nh;
    pm = m;
    pu = up;
    want.push_back({lc, hc, lc[5:2], 19'(ql), 19'(qh), 16'(nl), 16'(nh)});
    far_u.send(saq_sample_t'({16'(el), 16'(eh), 15'(dl), 15'(dh)}), keep);
  endtask

  task automatic drain();
    repeat (3) @(negedge CLK_I);
    check("result count", far_u.seen.size(), want.size());
    while (want.size() > 0 && far_u.seen.size() > 0) begin
      check("result", far_u.seen.pop_front(), want.pop_front());
    end
    want.delete();
    far_u.seen.delete();
  endtask

  task automatic t_reset(input int cycles);
    RST_N_I = 1'b0;
    repeat (cycles) @(negedge CLK_I);
    RST_N_I = 1'b1;
    check("reset result", RES_O, RES_RESET);
    check("reset log", {VALID_O, NABLA_L_O, NABLA_H_O, COEF_O}, 49'h0);
    nl = 0;
    nh = 0;
    pm = 1;
    pu = 1'b0;
  endtask

  // every interval edge, both signs, back to back, plus the extreme negative value
  task automatic t_sweep();
    int e;
    for (int k = 0; k < 30; k++) begin
      for (int j = 0; j < 2; j++) begin
        e = (int'(LO_FLOOR[k]) + 1) / 2 - j;
        put(e, k[0] ? j - 9024 : 9024 - j, 4096, 8192, 1'b1);
        put(-e, k[0] ? 9024 - j : j - 9024, 4096, 8192, 1'b1);
      end
    end
    put(-32768, -32768, 1, 1, 1'b0);
    drain();
  endtask

  // outermost codes drive the lower log factor into its ceiling and raise the higher one, then a
  // large scale checks that the clamp holds while products grow wide
  task automatic t_clamp();
    int d;
    for (int i = 0; i < 40; i++) begin
      d = (i < 20) ? 1 : 32767;
      put(32767, 32767, d, d, i < 39);
    end
    drain();
  endtask

  // a strobe while the enable is low must leave everything frozen
  task automatic t_hold();
    saq_result_t r;
    logic [31:0] n;
    put(256, -256, 4660, 1383, 1'b0);
    drain();
    r = RES_O;
    n = {NABLA_L_O, NABLA_H_O};
    CE_I = 1'b0;
    far_u.send(saq_sample_t'({16'h7000, 16'h7000, 15'h0001, 15'h0001}), 1'b0);
    CE_I = 1'b1;
    repeat (2) @(negedge CLK_I);
    check("frozen result", RES_O, r);
    check("frozen count", far_u.seen.size(), 0);
    check("frozen log", {NABLA_L_O, NABLA_H_O}, n);
  endtask

  // coefficient set is mirrored about the centre pair
  task automatic t_coef();
    for (int i = 0; i < 32; i++) begin
      COEF_IDX_I = 5'(i);
      @(negedge CLK_I);
      // both sides unsigned so a negative coefficient is not sign-extended on one side only
      check("coef", $unsigned(COEF_O),
        (i < 12) ? QMF_HALF[i] : (i < 24) ? QMF_HALF[23 - i] : 16'h0);
      if (i == 11 || i == 12) check("coef centre", COEF_O, 16'h3c90);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge CLK_I);
    err_count++;
    report_and_stop();
  end

  initial begin
    err_count = 0;
    compares = 0;
    RST_N_I = 1'b0;
    CE_I = 1'b1;
    COEF_IDX_I = 5'h00;
    @(negedge CLK_I);
    t_reset(3);
    t_sweep();
    t_clamp();
    t_reset(1);
    t_hold();
    t_coef();
    report_and_stop();
  end
endmodule
`default_nettype wire
